// >>> hdl/prs_sequencer.sv
`timescale 1ns/1ps
`include "prs_params.svh"
module prs_sequencer #(
  parameter int TICK_CYC = `PRS_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Supply state and power request
  input wire logic supplyGood,
  input wire logic nvmLoaded,
  input wire logic powerOnReq,
  // Internal comparators
  input wire logic inputIs5v,
  input wire logic coreIs0v85,
  // Strap and general pins
  input wire logic strapPinOneIn,
  output logic strapPinOneOut,
  output logic strapPinOneOe_n,
  input wire logic strapPinTwoIn,
  input wire logic generalPinFourIn,
  input wire logic generalPinSixIn,
  // Core enable pin five
  output logic generalPinFiveOut,
  output logic generalPinFiveOe_n,
  // Processor reset
  output logic resetOutputOut,
  output logic resetOutputOe_n,
  // Rail enables and selections
  output logic ioSupply3v3Enable,
  output logic linearRegTwoFuse,
  output logic stepDownOneEnable,
  output logic linearRegOneEnable,
  output logic linearRegThreeEnable,
  output logic stepDownTwoEnable,
  output logic stepDownFourEnable,
  output logic stepDownFour3v3,
  output logic stepDownThreeEnable,
  output logic coreMonitorHigh,
  output logic flexCoreAllowed,
  output logic watchdogLongWindowHold,
  output logic lowPowerModeReq
);

  prs_pkg::prs_state_t state_reg;
  logic [15:0] preCnt_reg;
  logic tickPulse;
  logic [8:0] tick_reg;
  logic [3:0] resourceSelectBits_reg;
  logic wdHold_reg;
  logic [3:0] config_reg;
  logic procErr_reg;
  logic lowPowerReq_reg;
  logic linear_reg_two_reg, io18_reg, dram_reg, ret_reg, core_reg, mem_reg, rstRel_reg;
  logic upPhase, downPhase;
  logic useStepFour, useStepThree;
  logic [31:0] statusWord;

  // Rail stays off in the down phase once dropped, so a shutdown
  // during ramp-up turns on a rail that was not yet up only when its up tick falls in the cycle the shutdown is seen.
  function automatic logic railNext(input logic up, input logic dn,
                                    input logic [8:0] tk, input logic [8:0] upTk,
                                    input logic [8:0] dnTk, input logic cur);
    logic r;
    r = 1'b0;
    if (up) begin
      r = (tk >= upTk);
    end else if (dn) begin
      r = cur && (tk < dnTk);
    end
    return r;
  endfunction : railNext

  assign upPhase = (state_reg == prs_pkg::SEQ_RAMP_UP) || (state_reg == prs_pkg::SEQ_ON);
  assign downPhase = (state_reg == prs_pkg::SEQ_RAMP_DOWN);
  assign tickPulse = (preCnt_reg == 16'(TICK_CYC - 1));
  assign useStepFour = resourceSelectBits_reg[1];
  assign useStepThree = !resourceSelectBits_reg[2] || (&resourceSelectBits_reg[1:0]);

  // Sequence state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= prs_pkg::SEQ_OFF;
    end else begin
      unique case (state_reg)
        prs_pkg::SEQ_OFF: begin
          if (supplyGood && nvmLoaded && powerOnReq) begin
            state_reg <= prs_pkg::SEQ_LATCH;
          end
        end
        prs_pkg::SEQ_LATCH: begin
          state_reg <= prs_pkg::SEQ_RAMP_UP;
        end
        prs_pkg::SEQ_RAMP_UP: begin
          if (!supplyGood || !powerOnReq) begin
            state_reg <= prs_pkg::SEQ_RAMP_DOWN;
          end else if (tick_reg >= `PRS_TK(`PRS_UP_RST_US)) begin
            state_reg <= prs_pkg::SEQ_ON;
          end
        end
        prs_pkg::SEQ_ON: begin
          if (!supplyGood || !powerOnReq) begin
            state_reg <= prs_pkg::SEQ_RAMP_DOWN;
          end
        end
        prs_pkg::SEQ_RAMP_DOWN: begin
          if (tick_reg >= `PRS_TK(`PRS_DN_LINEAR_REG_TWO_US)) begin
            state_reg <= prs_pkg::SEQ_OFF;
          end
        end
      endcase
    end
  end

  // Time base; restarts at each phase so step zero lines up with its start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      preCnt_reg <= 16'h0000;
      tick_reg <= 9'h000;
    end else if (state_reg == prs_pkg::SEQ_LATCH ||
                 (upPhase && (!supplyGood || !powerOnReq))) begin
      preCnt_reg <= 16'h0000;
      tick_reg <= 9'h000;
    end else if (tickPulse) begin
      preCnt_reg <= 16'h0000;
      if (tick_reg != 9'h1ff) begin
        tick_reg <= tick_reg + 9'h001;
      end
    end else begin
      preCnt_reg <= preCnt_reg + 16'h0001;
    end
  end

  // Cold boot straps, taken once and held for the whole power cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resourceSelectBits_reg <= 4'h0;
      wdHold_reg <= 1'b0;
    end else if (state_reg == prs_pkg::SEQ_LATCH) begin
      resourceSelectBits_reg <= {inputIs5v, coreIs0v85, strapPinOneIn, strapPinTwoIn};
      wdHold_reg <= generalPinSixIn;
    end
  end

  // Rail enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      linear_reg_two_reg <= 1'b0;
      io18_reg <= 1'b0;
      dram_reg <= 1'b0;
      ret_reg <= 1'b0;
      core_reg <= 1'b0;
      mem_reg <= 1'b0;
      rstRel_reg <= 1'b0;
    end else begin
      linear_reg_two_reg <= railNext(upPhase, downPhase, tick_reg, `PRS_TK(`PRS_UP_LINEAR_REG_TWO_US),
                           `PRS_TK(`PRS_DN_LINEAR_REG_TWO_US), linear_reg_two_reg);
      io18_reg <= railNext(upPhase, downPhase, tick_reg, `PRS_TK(`PRS_UP_IO_US),
                           `PRS_TK(`PRS_DN_IO_US), io18_reg);
      dram_reg <= railNext(upPhase, downPhase, tick_reg, `PRS_TK(`PRS_UP_DRAM_US),
                           `PRS_TK(`PRS_DN_DRAM_US), dram_reg);
      ret_reg <= useStepFour && railNext(upPhase, downPhase, tick_reg,
                 `PRS_TK(`PRS_UP_RET_US), `PRS_TK(`PRS_DN_RET_US), ret_reg);
      core_reg <= railNext(upPhase, downPhase, tick_reg, `PRS_TK(`PRS_UP_CORE_US),
                           `PRS_TK(`PRS_DN_CORE_US), core_reg);
      mem_reg <= useStepThree && railNext(upPhase, downPhase, tick_reg,
                 `PRS_TK(`PRS_UP_MEM_US), `PRS_TK(`PRS_DN_MEM_US), mem_reg);
      rstRel_reg <= railNext(upPhase, downPhase, tick_reg, `PRS_TK(`PRS_UP_RST_US),
                             `PRS_TK(`PRS_DN_RST_US), rstRel_reg);
    end
  end

  // Pin six turns error monitor once the 1.8V rail (io18_reg) is up; input is active low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      procErr_reg <= 1'b0;
    end else if (io18_reg && !generalPinSixIn) begin
      procErr_reg <= 1'b1;
    end else if (regWr && regAddr == `PRS_ADDR_ERRFLAG && regWrData[`PRS_ERR_PROC]) begin
      procErr_reg <= 1'b0;
    end
  end

  // Low-power request sampled only when pin one is the low-power input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowPowerReq_reg <= 1'b0;
    end else begin
      lowPowerReq_reg <= resourceSelectBits_reg[1] && !strapPinOneIn && upPhase;
    end
  end

  // Configuration, standing in for the non-volatile output settings
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      config_reg <= `PRS_CFG_RESET;
    end else if (regWr && regAddr == `PRS_ADDR_CONFIG) begin
      config_reg <= regWrData[3:0];
    end
  end

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`PRS_ST_RS_LSB +: 4] = resourceSelectBits_reg;
    statusWord[`PRS_ST_WDHOLD] = wdHold_reg;
    statusWord[`PRS_ST_POWERED] = (state_reg == prs_pkg::SEQ_ON);
    statusWord[`PRS_ST_BUSY] = (state_reg != prs_pkg::SEQ_ON) && (state_reg != prs_pkg::SEQ_OFF);
    statusWord[`PRS_ST_IO3V3] = !resourceSelectBits_reg[1] && generalPinFourIn;
    statusWord[`PRS_ST_LPREQ] = lowPowerReq_reg;
  end

  // Read data live only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `PRS_ADDR_CONFIG: regRdData <= {28'h0000000, config_reg};
        `PRS_ADDR_STATUS: regRdData <= statusWord;
        `PRS_ADDR_ERRFLAG: regRdData <= {31'h00000000, procErr_reg};
        default: regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // Pin drive; open-drain only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      generalPinFiveOut <= 1'b0;
      generalPinFiveOe_n <= 1'b0;
      resetOutputOut <= 1'b0;
      resetOutputOe_n <= 1'b0;
      strapPinOneOut <= 1'b0;
      strapPinOneOe_n <= 1'b1;
    end else begin
      generalPinFiveOut <= !config_reg[`PRS_CFG_CORE_OD] && core_reg;
      generalPinFiveOe_n <= config_reg[`PRS_CFG_CORE_OD] && core_reg;
      resetOutputOut <= !config_reg[`PRS_CFG_RST_OD] && rstRel_reg;
      resetOutputOe_n <= config_reg[`PRS_CFG_RST_OD] && rstRel_reg;
      strapPinOneOut <= resourceSelectBits_reg[0] ? config_reg[`PRS_CFG_FUSE_ON]
                                                  : config_reg[`PRS_CFG_SD_1V8];
      strapPinOneOe_n <= resourceSelectBits_reg[1] || !upPhase;
    end
  end

  assign ioSupply3v3Enable = linear_reg_two_reg;
  assign linearRegTwoFuse = resourceSelectBits_reg[0];
  assign stepDownOneEnable = io18_reg;
  assign linearRegOneEnable = io18_reg;
  assign linearRegThreeEnable = io18_reg;
  assign stepDownTwoEnable = dram_reg;
  assign stepDownFourEnable = ret_reg;
  assign stepDownFour3v3 = resourceSelectBits_reg[3];
  assign stepDownThreeEnable = mem_reg;
  assign coreMonitorHigh = resourceSelectBits_reg[2];
  assign flexCoreAllowed = &resourceSelectBits_reg[1:0];
  assign watchdogLongWindowHold = wdHold_reg;
  assign lowPowerModeReq = lowPowerReq_reg;

  property p_straps_hold;
    @(posedge clk_sys) disable iff (rst)
    (state_reg != prs_pkg::SEQ_LATCH) |=> $stable(resourceSelectBits_reg) && $stable(wdHold_reg);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("straps changed");

  property p_wd_latch;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == prs_pkg::SEQ_LATCH) |=> (wdHold_reg == $past(generalPinSixIn));
  endproperty
  a_wd_latch: assert property (p_wd_latch) else $error("watchdog strap not taken");

  property p_rs_latch;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == prs_pkg::SEQ_LATCH) ##1 1'b1 |-> resourceSelectBits_reg ==
      {$past(inputIs5v), $past(coreIs0v85), $past(strapPinOneIn), $past(strapPinTwoIn)};
  endproperty
  a_rs_latch: assert property (p_rs_latch) else $error("resource bits not taken");

  property p_strap_before_io;
    @(posedge clk_sys) disable iff (rst)
    $rose(io18_reg) |-> (tick_reg >= `PRS_TK(`PRS_UP_IO_US)) && $past(upPhase, 2);
  endproperty
  a_strap_before_io: assert property (p_strap_before_io) else $error("1.8V rail early");

  property p_linear_reg_two_first;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == prs_pkg::SEQ_LATCH) |-> ##2 linear_reg_two_reg;
  endproperty
  a_linear_reg_two_first: assert property (p_linear_reg_two_first) else $error("bypass regulator late");

  property p_reset_order;
    @(posedge clk_sys) disable iff (rst)
    rstRel_reg |-> core_reg && dram_reg && io18_reg && linear_reg_two_reg;
  endproperty
  a_reset_order: assert property (p_reset_order) else $error("reset released early");

  property p_reset_first_down;
    @(posedge clk_sys) disable iff (rst)
    $rose(state_reg == prs_pkg::SEQ_RAMP_DOWN) |-> ##1 !rstRel_reg;
  endproperty
  a_reset_first_down: assert property (p_reset_first_down) else $error("reset held");

  property p_step_four_gate;
    @(posedge clk_sys) disable iff (rst)
    ret_reg |-> resourceSelectBits_reg[1];
  endproperty
  a_step_four_gate: assert property (p_step_four_gate) else $error("fourth buck on");

  property p_pin_one_input;
    @(posedge clk_sys) disable iff (rst)
    resourceSelectBits_reg[1] |=> strapPinOneOe_n;
  endproperty
  a_pin_one_input: assert property (p_pin_one_input) else $error("pin one driven");

  property p_core_od;
    @(posedge clk_sys) disable iff (rst)
    config_reg[`PRS_CFG_CORE_OD] ##1 config_reg[`PRS_CFG_CORE_OD] |-> !generalPinFiveOut;
  endproperty
  a_core_od: assert property (p_core_od) else $error("open drain drove high");

  property p_pin_one_drive;
    @(posedge clk_sys) disable iff (rst)
    !resourceSelectBits_reg[1] && upPhase |=> !strapPinOneOe_n;
  endproperty
  a_pin_one_drive: assert property (p_pin_one_drive) else $error("pin one not driven");

  property p_err_set;
    @(posedge clk_sys) disable iff (rst)
    io18_reg && !generalPinSixIn |=> procErr_reg;
  endproperty
  a_err_set: assert property (p_err_set) else $error("processor error lost");

  property p_off_dark;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == prs_pkg::SEQ_OFF) |->
      !(linear_reg_two_reg || io18_reg || dram_reg || ret_reg || core_reg || mem_reg || rstRel_reg);
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("rail on while off");

endmodule : prs_sequencer

// >>> include/prs_params.svh
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_ADDR_CONFIG 8'h00
`define PRS_ADDR_STATUS 8'h04
`define PRS_ADDR_ERRFLAG 8'h08
`define PRS_CFG_CORE_OD 0
`define PRS_CFG_RST_OD 1
`define PRS_CFG_FUSE_ON 2
`define PRS_CFG_SD_1V8 3
`define PRS_CFG_RESET 4'h2
`define PRS_ST_RS_LSB 0
`define PRS_ST_WDHOLD 4
`define PRS_ST_POWERED 5
`define PRS_ST_BUSY 6
`define PRS_ST_IO3V3 7
`define PRS_ST_LPREQ 8
`define PRS_ERR_PROC 0
`define PRS_CLK_PERIOD_NS 8
`define PRS_TICK_NS 50000
`define PRS_TICK_CYC (`PRS_TICK_NS / `PRS_CLK_PERIOD_NS)
`define PRS_TK(us) (9'((us) * 1000 / `PRS_TICK_NS))
`define PRS_UP_LINEAR_REG_TWO_US 0
`define PRS_UP_IO_US 2500
`define PRS_UP_DRAM_US 4800
`define PRS_UP_RET_US 5400
`define PRS_UP_CORE_US 5950
`define PRS_UP_MEM_US 7450
`define PRS_UP_RST_US 14800
`define PRS_DN_LINEAR_REG_TWO_US 2500
`define PRS_DN_IO_US 2000
`define PRS_DN_DRAM_US 1500
`define PRS_DN_RET_US 1000
`define PRS_DN_CORE_US 1000
`define PRS_DN_MEM_US 500
`define PRS_DN_RST_US 0
`endif

// >>> include/prs_pkg.sv
package prs_pkg;
  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_LATCH,
    SEQ_RAMP_UP,
    SEQ_ON,
    SEQ_RAMP_DOWN
  } prs_state_t;
endpackage : prs_pkg

// >>> bench/prs_board_model.sv
`timescale 1ns/1ps
module prs_board_model (
  // Board fitting options
  input wire logic pullDownOne,
  input wire logic pullDownTwo,
  input wire logic wdStrapHigh,
  input wire logic procFault,
  // Device pins
  input wire logic strapPinOneOut,
  input wire logic strapPinOneOe_n,
  input wire logic ioRail1v8,
  input wire logic io3v3Enable,
  output logic strapPinOneIn,
  output logic strapPinTwoIn,
  output logic generalPinFourIn,
  output logic generalPinSixIn
);
  // Weak pull-up wins unless the 10k pull-down is fitted
  assign strapPinOneIn = !strapPinOneOe_n ? strapPinOneOut : !pullDownOne;
  assign strapPinTwoIn = !pullDownTwo;
  assign generalPinFourIn = io3v3Enable;
  // Buffer hides the processor until the 1.8V rail is up
  assign generalPinSixIn = ioRail1v8 ? !procFault : wdStrapHigh;
endmodule : prs_board_model

// >>> bench/pmic_resource_select_sequencer_tb.sv
`timescale 1ns/1ps
`include "prs_params.svh"
module pmic_resource_select_sequencer_tb;
  localparam int TICK = 4;
  localparam int UP[9] = '{0, 50, 50, 50, 96, 108, 119, 149, 296};
  localparam int DN[9] = '{50, 40, 40, 40, 30, 20, 20, 10, 0};
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic supplyGood = 1'h0, nvmLoaded = 1'h0, powerOnReq = 1'h0;
  logic inputIs5v = 1'h0, coreIs0v85 = 1'h0;
  logic pullDownOne = 1'h0, pullDownTwo = 1'h0, wdStrapHigh = 1'h0, procFault = 1'h0;
  logic [31:0] regRdData;
  logic strapPinOneIn, strapPinOneOut, strapPinOneOe_n, strapPinTwoIn;
  logic generalPinFourIn, generalPinSixIn, generalPinFiveOut, generalPinFiveOe_n;
  logic resetOutputOut, resetOutputOe_n, ioSupply3v3Enable, linearRegTwoFuse;
  logic stepDownOneEnable, linearRegOneEnable, linearRegThreeEnable, stepDownTwoEnable;
  logic stepDownFourEnable, stepDownFour3v3, stepDownThreeEnable, coreMonitorHigh;
  logic flexCoreAllowed, watchdogLongWindowHold, lowPowerModeReq;
  logic [8:0] rails;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  prs_sequencer #(.TICK_CYC(TICK)) u_prs_sequencer (.clk_sys, .rst, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .supplyGood, .nvmLoaded, .powerOnReq, .inputIs5v,
    .coreIs0v85, .strapPinOneIn, .strapPinOneOut, .strapPinOneOe_n, .strapPinTwoIn,
    .generalPinFourIn, .generalPinSixIn, .generalPinFiveOut, .generalPinFiveOe_n,
    .resetOutputOut, .resetOutputOe_n, .ioSupply3v3Enable, .linearRegTwoFuse,
    .stepDownOneEnable, .linearRegOneEnable, .linearRegThreeEnable, .stepDownTwoEnable,
    .stepDownFourEnable, .stepDownFour3v3, .stepDownThreeEnable, .coreMonitorHigh,
    .flexCoreAllowed, .watchdogLongWindowHold, .lowPowerModeReq);

  prs_board_model u_prs_board_model (.pullDownOne, .pullDownTwo, .wdStrapHigh, .procFault,
    .strapPinOneOut, .strapPinOneOe_n, .ioRail1v8(stepDownOneEnable),
    .io3v3Enable(ioSupply3v3Enable), .strapPinOneIn, .strapPinTwoIn, .generalPinFourIn,
    .generalPinSixIn);

  // Reset pin is open-drain by default, so release shows on the enable
  assign rails = {resetOutputOe_n, stepDownThreeEnable, generalPinFiveOut,
    stepDownFourEnable, stepDownTwoEnable, linearRegThreeEnable, linearRegOneEnable,
    stepDownOneEnable, ioSupply3v3Enable};

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Tolerance absorbs tick phase against the request edge
  task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic ok;
    ok = (tol == 0) ? got === exp : (!$isunknown(got) && got <= exp + tol && got + tol >= exp);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask : regWrite

  task regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 d = regRdData;
  endtask : regRead

  // First cycle at which each rail leaves its starting level, or -1
  task watch(input int n, output int t[9]);
    logic [8:0] s0;
    s0 = rails;
    for (int i = 0; i < 9; i++) t[i] = -1;
    for (int c = 1; c <= n; c++) begin
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 9; i++) if (t[i] < 0 && rails[i] !== s0[i]) t[i] = c;
    end
  endtask : watch

  function automatic bit used(input int i, input logic [3:0] rs);
    return !(i == 5 && !rs[1]) && !(i == 7 && rs[2] && !(rs[1] && rs[0]));
  endfunction : used

  task regsTest();
    logic [31:0] d;
    regRead(`PRS_ADDR_CONFIG, d);
    chk(d, `PRS_CFG_RESET, 0);
    regRead(8'h0c, d);
    chk(d, 32'h0, 0);
    regWrite(`PRS_ADDR_STATUS, 32'hffffffff);
    regRead(`PRS_ADDR_STATUS, d);
    chk(d, 32'h0, 0);
    $display("register test done");
  endtask : regsTest

  task bootTest(input logic [3:0] rs, input logic wd);
    int t[9];
    logic [31:0] d;
    @(posedge clk_sys);
    inputIs5v <= rs[3];
    coreIs0v85 <= rs[2];
    pullDownOne <= !rs[1];
    pullDownTwo <= !rs[0];
    wdStrapHigh <= wd;
    supplyGood <= 1'h1;
    nvmLoaded <= 1'h1;
    powerOnReq <= 1'h1;
    watch(1300, t);
    chk(t[0], 32'd3, 0);
    for (int i = 1; i < 9; i++) begin
      if (used(i, rs)) chk(t[i] - t[0], UP[i] * TICK, TICK + 1);
      else chk(t[i], 32'hffffffff, 0);
    end
    chk({stepDownFour3v3, coreMonitorHigh, flexCoreAllowed, linearRegTwoFuse},
      {rs[3], rs[2], rs[1] & rs[0], rs[0]}, 0);
    chk(watchdogLongWindowHold, wd, 0);
    chk(strapPinOneOe_n, rs[1], 0);
    regRead(`PRS_ADDR_STATUS, d);
    chk(d[4:0], {wd, rs}, 0);
    // Straps move while powered; latched copies must not
    @(posedge clk_sys);
    inputIs5v <= !rs[3];
    coreIs0v85 <= !rs[2];
    pullDownOne <= rs[1];
    pullDownTwo <= rs[0];
    wdStrapHigh <= !wd;
    regRead(`PRS_ADDR_STATUS, d);
    chk(d[4:0], {wd, rs}, 0);
    chk(d[8:5], {rs[1], !rs[1], 2'h1}, 0);
    chk(lowPowerModeReq, rs[1], 0);
    // No error flagged while the processor was isolated
    regRead(`PRS_ADDR_ERRFLAG, d);
    chk(d[0], 1'h0, 0);
    // Processor error reaches pin six once the buffer is on
    @(posedge clk_sys);
    procFault <= 1'h1;
    repeat (3) @(posedge clk_sys);
    procFault <= 1'h0;
    regRead(`PRS_ADDR_ERRFLAG, d);
    chk(d[0], 1'h1, 0);
    regWrite(`PRS_ADDR_ERRFLAG, 32'h1);
    regRead(`PRS_ADDR_ERRFLAG, d);
    chk(d[0], 1'h0, 0);
    regWrite(`PRS_ADDR_CONFIG, 32'h0);
    @(posedge clk_sys);
    #1 chk({resetOutputOe_n, resetOutputOut, generalPinFiveOe_n, generalPinFiveOut}, 4'h5, 0);
    chk(strapPinOneOut, 1'h0, 0);
    regWrite(`PRS_ADDR_CONFIG, 32'h7);
    @(posedge clk_sys);
    #1 chk({resetOutputOe_n, resetOutputOut, generalPinFiveOe_n, generalPinFiveOut}, 4'ha, 0);
    chk(strapPinOneOut, rs[0], 0);
    regWrite(`PRS_ADDR_CONFIG, 32'h8);
    @(posedge clk_sys);
    #1 chk(strapPinOneOut, !rs[0], 0);
    regWrite(`PRS_ADDR_CONFIG, `PRS_CFG_RESET);
    // Let the pin flops settle so the watch starts from the real levels
    repeat (2) @(posedge clk_sys);
    powerOnReq <= 1'h0;
    watch(260, t);
    for (int i = 0; i < 9; i++) begin
      if (used(i, rs)) chk(t[i], DN[i] * TICK, TICK + 2);
      else chk(t[i], 32'hffffffff, 0);
    end
    $display("boot test rs=%h wd=%h done", rs, wd);
  endtask : bootTest

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    regsTest();
    bootTest(4'h4, 1'h0);
    bootTest(4'hb, 1'h1);
    bootTest(4'h7, 1'h0);
    bootTest(4'h8, 1'h1);
    end_of_test();
  end
endmodule : pmic_resource_select_sequencer_tb
